/* ctl_regs_pkg.sv */
package ctl_regs_pkg;

  // Control register numbers
  localparam logic [4:0] REG_STATE      = 5'h00;
  localparam logic [4:0] REG_EXC_SAVED  = 5'h01;
  localparam logic [4:0] REG_BRK_SAVED  = 5'h02;
  localparam logic [4:0] REG_IRQ_MASK   = 5'h03;
  localparam logic [4:0] REG_IRQ_PEND   = 5'h04;
  localparam logic [4:0] REG_CORE_ID    = 5'h05;
  localparam logic [4:0] REG_CAUSE      = 5'h07;
  localparam logic [4:0] REG_PTE_PTR    = 5'h08;
  localparam logic [4:0] REG_TLB_ACC    = 5'h09;
  localparam logic [4:0] REG_TLB_MISC   = 5'h0A;
  localparam logic [4:0] REG_BAD_ADDR   = 5'h0C;
  localparam logic [4:0] REG_PROT_SETUP = 5'h0D;
  localparam logic [4:0] REG_REG_BASE   = 5'h0E;
  localparam logic [4:0] REG_REG_PERM   = 5'h0F;

  // Processor state field positions
  localparam int SET_IRQ_ALLOW_BIT = 23;
  localparam int NMI_MODE_BIT      = 22;
  localparam int PREV_SET_LSB      = 16;
  localparam int ACT_SET_LSB       = 10;
  localparam int LEVEL_LSB         = 4;
  localparam int IRQ_HANDLER_BIT   = 3;
  localparam int EXC_HANDLER_BIT   = 2;
  localparam int USER_BIT          = 1;
  localparam int GLOBAL_ALLOW_BIT  = 0;
  localparam int SET_FIELD_W       = 6;
  localparam int LEVEL_W           = 6;

  // Field reset values
  localparam logic       SET_IRQ_ALLOW_RST = 1'b1;
  localparam logic       FLAG_RST          = 1'b0;
  localparam logic [5:0] FIELD_RST         = 6'h00;
  localparam logic [31:0] WORD_RST         = 32'h0000_0000;

  // Host-side order codes for the controller port
  localparam logic [3:0] HREG_CMD      = 4'h0;
  localparam logic [3:0] HREG_WDATA    = 4'h1;
  localparam logic [3:0] HREG_RDATA    = 4'h2;
  localparam logic [3:0] HREG_STATUS   = 4'h3;
  localparam logic [3:0] HREG_EVENT    = 4'h4;

  // Event kinds on the link
  typedef enum logic [2:0]
  {
    EV_NONE   = 3'h0,
    EV_EXC    = 3'h1,
    EV_BREAK  = 3'h3,
    EV_IRQ    = 3'h2,
    EV_NMI    = 3'h6,
    EV_RET_E  = 3'h7,
    EV_RET_B  = 3'h5
  } event_kind_t;

endpackage : ctl_regs_pkg

/* ctl_link_if.sv */
`timescale 1ns/100ps
interface ctl_link_if;
  import ctl_regs_pkg::*;
  logic        rd_req;       // Read move instruction
  logic        wr_req;       // Write move instruction
  logic [4:0]  regnum;       // Control register number
  logic [31:0] wdata;        // Write data
  logic [31:0] rdata;        // Read data, cycle after read
  logic        supervisor;   // Core is in supervisor mode
  event_kind_t ev_kind;      // Exception or interrupt event
  logic [5:0]  ev_set;       // Requested register set
  logic [5:0]  ev_level;     // Requested interrupt level
  logic        irq_accept;   // Core accepts a maskable request now
  logic        miss_double;  // Translation miss class
  logic [31:0] irq_lines;    // Internal interrupt inputs

  modport core
  (
    input  rd_req, wr_req, regnum, wdata, ev_kind, ev_set, ev_level, irq_lines,
    output rdata, supervisor, irq_accept, miss_double
  );
  modport sw
  (
    output rd_req, wr_req, regnum, wdata, ev_kind, ev_set, ev_level, irq_lines,
    input  rdata, supervisor, irq_accept, miss_double
  );
endinterface : ctl_link_if

/* ctl_regs_core.sv */
// Behaviour
// - Access only by move ops, supervisor mode
// - Software writes undefined bits as zero
// - Five-bit number, reserved 6,11,16-31
// - Fixed numbers for listed registers
// - Registers 8-10 only with MMU
// - Registers 13-15 only with MPU
// - Registers 3,4 only without external controller
// - State register loads reset values
// - State register bit layout fixed
// - NMI mode set by core, read-only
// - Copy active set to previous set
// - Copy follows saving of state
// - Set fields use only needed bits
// - Software writes only implemented set numbers
// - Active set cleared on noninterrupt exception
// - Serve level strictly above threshold
// - Interrupt sets handler flag
// - Handler flag classifies translation misses
// - Unimplemented fields read constant value
// - User bit selects user mode
// - Global allow gates maskable interrupts
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module ctl_regs_core
#(
  parameter bit          HAS_MMU   = 1'b1,
  parameter bit          HAS_MPU   = 1'b0,
  parameter bit          HAS_EIC   = 1'b1,
  parameter int          SET_BITS  = 2,
  parameter logic [31:0] CORE_ID   = 32'h0000_0001  // Arbitrary value
)
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  ctl_link_if.core                  link,
  input  wire logic [31:0]          cause_in,
  input  wire logic [31:0]          bad_addr_in,
  input  wire logic                 miss_in,
  output logic                      miss_double_seen,
  output logic [31:0]               state_out
);
  import ctl_regs_pkg::*;

  localparam logic [5:0] SET_MASK = 6'((1 << SET_BITS) - 1);
  localparam bit HAS_SHADOW = (SET_BITS > 0);

  // Whole module state
  typedef struct packed
  {
    logic        set_irq_allow;
    logic        nmi_mode;
    logic [5:0]  previous_set_field;
    logic [5:0]  active_set_field;
    logic [5:0]  irq_level_threshold;
    logic        irq_handler_flag;
    logic        exc_handler_flag;
    logic        user_mode;
    logic        global_irq_allow;
    logic [31:0] exc_saved;
    logic [31:0] brk_saved;
    logic [31:0] irq_mask;
    logic [31:0] pte_ptr;
    logic [31:0] tlb_acc;
    logic [31:0] tlb_misc;
    logic [31:0] prot_setup;
    logic [31:0] reg_base;
    logic [31:0] reg_perm;
    logic [31:0] rdata;
    logic        miss_double;
  } core_state_t;

  core_state_t st_reg;     // Registered state
  core_state_t st_next;    // Next state
  logic [31:0] state_word; // Assembled state register view
  logic [31:0] rd_val;     // Read mux output
  logic        reg_valid;  // Number maps to an existing register
  logic        irq_ok;     // Maskable request may be taken now

  // Assemble state word, unimplemented fields read constant
  always_comb
  begin
    state_word = WORD_RST;
    state_word[SET_IRQ_ALLOW_BIT] = (HAS_EIC && HAS_SHADOW) ? st_reg.set_irq_allow
                                                            : 1'b1;
    state_word[NMI_MODE_BIT] = HAS_EIC ? st_reg.nmi_mode : 1'b0;
    state_word[PREV_SET_LSB +: SET_FIELD_W] = st_reg.previous_set_field & SET_MASK;
    state_word[ACT_SET_LSB +: SET_FIELD_W] = st_reg.active_set_field & SET_MASK;
    state_word[LEVEL_LSB +: LEVEL_W] = HAS_EIC ? st_reg.irq_level_threshold : FIELD_RST;
    state_word[IRQ_HANDLER_BIT] = HAS_EIC ? st_reg.irq_handler_flag : 1'b0;
    state_word[EXC_HANDLER_BIT] = HAS_MMU ? st_reg.exc_handler_flag : 1'b0;
    state_word[USER_BIT] = (HAS_MMU || HAS_MPU) ? st_reg.user_mode : 1'b0;
    state_word[GLOBAL_ALLOW_BIT] = st_reg.global_irq_allow;
  end

  // Register existence by configuration
  always_comb
  begin
    case (link.regnum)
      REG_STATE, REG_EXC_SAVED, REG_BRK_SAVED, REG_CORE_ID, REG_CAUSE, REG_BAD_ADDR:
        reg_valid = 1'b1;
      REG_IRQ_MASK, REG_IRQ_PEND:
        reg_valid = !HAS_EIC;
      REG_PTE_PTR, REG_TLB_ACC, REG_TLB_MISC:
        reg_valid = HAS_MMU;
      REG_PROT_SETUP, REG_REG_BASE, REG_REG_PERM:
        reg_valid = HAS_MPU;
      default:
        reg_valid = 1'b0;
    endcase
  end

  // Read mux, reserved numbers give zero
  always_comb
  begin
    rd_val = WORD_RST;
    if (reg_valid)
    begin
      case (link.regnum)
        REG_STATE:      rd_val = state_word;
        REG_EXC_SAVED:  rd_val = st_reg.exc_saved;
        REG_BRK_SAVED:  rd_val = st_reg.brk_saved;
        REG_IRQ_MASK:   rd_val = st_reg.irq_mask;
        REG_IRQ_PEND:   rd_val = link.irq_lines & st_reg.irq_mask;
        REG_CORE_ID:    rd_val = CORE_ID;
        REG_CAUSE:      rd_val = cause_in;
        REG_PTE_PTR:    rd_val = st_reg.pte_ptr;
        REG_TLB_ACC:    rd_val = st_reg.tlb_acc;
        REG_TLB_MISC:   rd_val = st_reg.tlb_misc;
        REG_BAD_ADDR:   rd_val = bad_addr_in;
        REG_PROT_SETUP: rd_val = st_reg.prot_setup;
        REG_REG_BASE:   rd_val = st_reg.reg_base;
        REG_REG_PERM:   rd_val = st_reg.reg_perm;
        default:        rd_val = WORD_RST;
      endcase
    end
  end

  // Next-state: software writes, then hardware events
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = WORD_RST;
    st_next.miss_double = miss_in ? st_reg.exc_handler_flag : st_reg.miss_double;
    // Moves only honoured in supervisor mode
    if (link.rd_req && !st_reg.user_mode)
      st_next.rdata = rd_val;
    if (link.wr_req && !st_reg.user_mode && reg_valid)
    begin
      case (link.regnum)
        REG_STATE:
        begin
          // Active set and NMI mode are read-only
          st_next.set_irq_allow = link.wdata[SET_IRQ_ALLOW_BIT];
          st_next.previous_set_field = link.wdata[PREV_SET_LSB +: SET_FIELD_W] & SET_MASK;
          st_next.irq_level_threshold = link.wdata[LEVEL_LSB +: LEVEL_W];
          st_next.irq_handler_flag = link.wdata[IRQ_HANDLER_BIT];
          st_next.exc_handler_flag = link.wdata[EXC_HANDLER_BIT];
          st_next.user_mode = link.wdata[USER_BIT];
          st_next.global_irq_allow = link.wdata[GLOBAL_ALLOW_BIT];
        end
        REG_EXC_SAVED:  st_next.exc_saved = link.wdata;
        REG_BRK_SAVED:  st_next.brk_saved = link.wdata;
        REG_IRQ_MASK:   st_next.irq_mask = link.wdata;
        REG_PTE_PTR:    st_next.pte_ptr = link.wdata;
        REG_TLB_ACC:    st_next.tlb_acc = link.wdata;
        REG_TLB_MISC:   st_next.tlb_misc = link.wdata;
        REG_PROT_SETUP: st_next.prot_setup = link.wdata;
        REG_REG_BASE:   st_next.reg_base = link.wdata;
        REG_REG_PERM:   st_next.reg_perm = link.wdata;
        default:        st_next.rdata = WORD_RST;
      endcase
    end
    // Hardware events win over a same-cycle write
    case (link.ev_kind)
      EV_EXC, EV_BREAK:
      begin
        // Save state, then copy active into previous set
        if (link.ev_kind == EV_BREAK)
          st_next.brk_saved = state_word;
        else if (!st_reg.exc_handler_flag || !HAS_MMU)
          st_next.exc_saved = state_word;
        if (!HAS_MMU || link.ev_kind == EV_BREAK || !st_reg.exc_handler_flag)
          st_next.previous_set_field = st_reg.active_set_field;
        st_next.active_set_field = FIELD_RST;
        st_next.exc_handler_flag = HAS_MMU;
        st_next.global_irq_allow = 1'b0;
        st_next.user_mode = 1'b0;
      end
      EV_IRQ, EV_NMI:
      begin
        if (link.ev_kind == EV_NMI || irq_ok)
        begin
          if (!st_reg.exc_handler_flag)
            st_next.exc_saved = state_word;
          if (!HAS_MMU || !st_reg.exc_handler_flag)
            st_next.previous_set_field = st_reg.active_set_field;
          st_next.active_set_field = link.ev_set & SET_MASK;
          st_next.irq_level_threshold = link.ev_level;
          st_next.irq_handler_flag = 1'b1;
          st_next.exc_handler_flag = HAS_MMU;
          st_next.nmi_mode = (link.ev_kind == EV_NMI);
          st_next.global_irq_allow = 1'b0;
          st_next.user_mode = 1'b0;
        end
      end
      default:
        st_next.miss_double = st_next.miss_double;
    endcase
  end

  // Maskable acceptance: global allow, level, set allow
  always_comb
  begin
    irq_ok = HAS_EIC && st_reg.global_irq_allow
             && (link.ev_level > st_reg.irq_level_threshold)
             && (state_word[SET_IRQ_ALLOW_BIT]
                 || ((link.ev_set & SET_MASK) != (st_reg.active_set_field & SET_MASK)));
  end

  // State register with reset values
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.set_irq_allow <= SET_IRQ_ALLOW_RST;
    end
    else
      st_reg <= st_next;
  end

  assign link.rdata       = st_reg.rdata;
  assign link.supervisor  = !st_reg.user_mode;
  assign link.irq_accept  = irq_ok;
  assign link.miss_double = st_reg.miss_double;
  assign miss_double_seen = st_reg.miss_double;
  assign state_out        = state_word;

endmodule : ctl_regs_core

/* ctl_regs_sw.sv */
`timescale 1ns/100ps
module ctl_regs_sw
#(
  parameter int SET_BITS = 2
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  ctl_link_if.sw           link,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);
  import ctl_regs_pkg::*;

  // Host state
  typedef struct packed
  {
    logic        rd_req;
    logic        wr_req;
    logic [4:0]  regnum;
    logic [31:0] wdata;
    logic [31:0] cap;
    logic        cap_due;
    logic [2:0]  ev_kind;
    logic [5:0]  ev_set;
    logic [5:0]  ev_level;
    logic [31:0] irq_lines;
    logic [31:0] rdata;
  } host_state_t;

  host_state_t h_reg;   // Registered host state
  host_state_t h_next;  // Next host state

  // Order decode and move issue
  always_comb
  begin
    h_next = h_reg;
    h_next.rd_req = 1'b0;
    h_next.wr_req = 1'b0;
    h_next.ev_kind = EV_NONE;
    h_next.rdata = WORD_RST;
    h_next.cap_due = h_reg.rd_req;
    if (h_reg.cap_due)
      h_next.cap = link.rdata;
    if (wr)
    begin
      case (addr)
        HREG_CMD:
        begin
          // Bit 0 read, bit 1 write; bits 8:4 register number
          h_next.regnum = wdata[8:4];
          h_next.rd_req = wdata[0] & link.supervisor;
          h_next.wr_req = wdata[1] & link.supervisor & ~wdata[0];
        end
        HREG_WDATA:
        begin
          // Undefined bits and unused previous-set bits forced to zero
          h_next.wdata = wdata & 32'h00FF_FFFF;
          h_next.wdata[PREV_SET_LSB +: SET_FIELD_W] =
            wdata[PREV_SET_LSB +: SET_FIELD_W] & 6'((1 << SET_BITS) - 1);
        end
        HREG_EVENT:
        begin
          h_next.ev_kind = wdata[2:0];
          h_next.ev_set = wdata[13:8] & 6'((1 << SET_BITS) - 1);
          h_next.ev_level = wdata[21:16];
        end
        HREG_RDATA:
          h_next.irq_lines = wdata;
        default:
          h_next.rdata = WORD_RST;
      endcase
    end
    if (rd)
    begin
      case (addr)
        HREG_RDATA:  h_next.rdata = h_reg.cap;
        HREG_STATUS: h_next.rdata = {29'h0, link.miss_double, link.irq_accept,
                                     link.supervisor};
        HREG_WDATA:  h_next.rdata = h_reg.wdata;
        default:     h_next.rdata = WORD_RST;
      endcase
    end
  end

  // Host registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      h_reg <= '0;
    else
      h_reg <= h_next;
  end

  assign link.rd_req    = h_reg.rd_req;
  assign link.wr_req    = h_reg.wr_req;
  assign link.regnum    = h_reg.regnum;
  assign link.wdata     = h_reg.wdata;
  assign link.ev_kind   = event_kind_t'(h_reg.ev_kind);
  assign link.ev_set    = h_reg.ev_set;
  assign link.ev_level  = h_reg.ev_level;
  assign link.irq_lines = h_reg.irq_lines;
  assign rdata          = h_reg.rdata;

endmodule : ctl_regs_sw

/* ctl_regs_props.sv */
`timescale 1ns/100ps
module ctl_regs_props
#(
  parameter bit          HAS_MPU  = 1'b0,
  parameter bit          HAS_EIC  = 1'b1,
  parameter int          SET_BITS = 2,
  parameter logic [31:0] CORE_ID  = 32'h0000_0001  // Arbitrary value
)
(
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      rd_req,
  input wire logic                      wr_req,
  input wire logic [4:0]                regnum,
  input wire logic [31:0]               wdata,
  input wire logic [31:0]               rdata,
  input wire logic                      supervisor,
  input wire ctl_regs_pkg::event_kind_t ev_kind,
  input wire logic [5:0]                ev_set,
  input wire logic [5:0]                ev_level,
  input wire logic                      irq_accept,
  input wire logic                      miss_double,
  input wire logic [31:0]               irq_lines
);
  import ctl_regs_pkg::*;
  logic rsvd_num;      // Number that reads as zero
  logic nmi_seen_reg;  // Nonmaskable event taken
  logic nmi_seen_next; // Next sticky value

  // Reserved or unconfigured numbers
  always_comb rsvd_num = regnum == 5'h06 || regnum == 5'h0B || regnum >= 5'h10
    || (!HAS_MPU && regnum inside {[5'h0D:5'h0F]}) || (HAS_EIC && regnum inside {5'h03, 5'h04});
  // Sticky flag of nonmaskable events
  always_comb nmi_seen_next = nmi_seen_reg | (ev_kind == EV_NMI);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      nmi_seen_reg <= 1'b0;
    else
      nmi_seen_reg <= nmi_seen_next;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Privileged read of the state register
  sequence s_state_rd;
    rd_req && supervisor && regnum == REG_STATE;
  endsequence

  a_rsvd_read_zero: assert property (rd_req && supervisor && rsvd_num |=> rdata == 32'h0)
    else $error("Reserved number read back nonzero");
  a_id_read_fixed: assert property (rd_req && supervisor && regnum == REG_CORE_ID
    |=> rdata == CORE_ID) else $error("Core identifier read wrong");
  a_state_unused_zero: assert property (s_state_rd |=> rdata[31:24] == 8'h00
    && rdata[21:16+SET_BITS] == '0 && rdata[15:10+SET_BITS] == '0)
    else $error("Unused state bits read nonzero");
  a_nmi_mode_flag: assert property ((s_state_rd ##0 ev_kind == EV_NONE)
    |=> rdata[NMI_MODE_BIT] == $past(nmi_seen_reg)) else $error("Nonmaskable mode bit wrong");
  a_exc_to_super: assert property (ev_kind == EV_EXC |=> supervisor)
    else $error("Exception left user mode on");
  a_exc_blocks_irq: assert property (ev_kind == EV_EXC |=> !irq_accept)
    else $error("Interrupt accepted after exception");
  a_level_above_zero: assert property (irq_accept |-> ev_level != 6'h00)
    else $error("Level zero request accepted");
  a_reset_super: assert property ($fell(rst) |-> supervisor)
    else $error("User mode on after reset");
endmodule : ctl_regs_props

/* tb.sv */
`timescale 1ns/100ps
module tb;
  import ctl_regs_pkg::*;
  logic        clk;              // Core clock
  logic        rst;              // Async reset
  logic [3:0]  addr;             // Host address
  logic [31:0] wdata;            // Host write data
  logic        wr;               // Host write strobe
  logic        rd;               // Host read strobe
  logic [31:0] rdata;            // Host read data
  logic [31:0] cause_in;         // Fault cause level
  logic [31:0] bad_addr_in;      // Faulting address level
  logic        miss_in;          // Translation miss pulse
  logic        miss_double_seen; // Miss class seen
  logic [31:0] state_out;        // State view
  int          err_total;        // Mismatches
  int          checks_done;      // Comparisons
  logic [4:0]  rsvd [9] = '{5'h03, 5'h04, 5'h06, 5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h1F};

  ctl_link_if link();
  ctl_regs_core ctl_regs_core_inst (.clk(clk), .rst(rst), .link(link),
    .cause_in(cause_in), .bad_addr_in(bad_addr_in), .miss_in(miss_in),
    .miss_double_seen(miss_double_seen), .state_out(state_out));
  ctl_regs_sw ctl_regs_sw_inst (.clk(clk), .rst(rst), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ctl_regs_props #(.HAS_MPU(1'b0), .HAS_EIC(1'b1), .SET_BITS(2), .CORE_ID(32'h0000_0001))
    ctl_regs_props_inst (.clk(clk), .rst(rst), .rd_req(link.rd_req), .wr_req(link.wr_req),
    .regnum(link.regnum), .wdata(link.wdata), .rdata(link.rdata),
    .supervisor(link.supervisor), .ev_kind(link.ev_kind), .ev_set(link.ev_set),
    .ev_level(link.ev_level), .irq_accept(link.irq_accept),
    .miss_double(link.miss_double), .irq_lines(link.irq_lines));

  // Clock
  always #2 clk = ~clk;

  // Masked compare
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checks_done++;
    if (((got ^ exp) & msk) !== 32'h0)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Host write
  task automatic hw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : hw

  // Host read and compare
  task automatic hr(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(rdata, exp, msk);
  endtask : hr

  // Control register read over the link
  task automatic crd(input logic [4:0] n, input logic [31:0] exp, input logic [31:0] msk);
    hw(4'h0, (32'(n) << 4) | 32'h1);
    repeat (3) @(posedge clk);
    hr(4'h2, exp, msk);
  endtask : crd

  // Control register write over the link
  task automatic cwr(input logic [4:0] n, input logic [31:0] d);
    hw(4'h1, d);
    hw(4'h0, (32'(n) << 4) | 32'h2);
    repeat (3) @(posedge clk);
  endtask : cwr

  // Event with set and level
  task automatic ev(input event_kind_t k, input logic [5:0] s, input logic [5:0] l);
    hw(4'h4, (32'(l) << 16) | (32'(s) << 8) | 32'(k));
    repeat (2) @(posedge clk);
  endtask : ev

  // Translation miss pulse
  task automatic miss();
    @(posedge clk);
    miss_in <= 1'b1;
    @(posedge clk);
    miss_in <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : miss

  // Verdict
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    cause_in = 32'h0000_0024;
    bad_addr_in = 32'h1000_0ABC;
    miss_in = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    crd(REG_STATE, 32'h0080_0000, '1);
    cmp(state_out, 32'h0080_0000, '1);
    hr(4'h3, 32'h1, 32'h7);
    cwr(REG_CORE_ID, '1);
    crd(REG_CORE_ID, 32'h1, '1);
    crd(REG_CAUSE, 32'h0000_0024, '1);
    @(posedge clk);
    cause_in <= 32'h0000_0030;
    crd(REG_CAUSE, 32'h0000_0030, '1);
    crd(REG_BAD_ADDR, 32'h1000_0ABC, '1);
    hw(4'h2, '1);
    foreach (rsvd[k])
    begin
      cwr(rsvd[k], '1);
      crd(rsvd[k], 32'h0, '1);
    end
    hw(4'h5, '1);
    hr(4'h5, 32'h0, '1);
    cwr(REG_EXC_SAVED, 32'h0082_0805);
    cwr(REG_BRK_SAVED, 32'h0001_0403);
    crd(REG_EXC_SAVED, 32'h0082_0805, '1);
    crd(REG_BRK_SAVED, 32'h0001_0403, '1);
    cwr(REG_STATE, 32'h00C1_0C59);
    crd(REG_STATE, 32'h0081_0059, '1);
    ev(EV_NONE, 6'h1, 6'h5);
    hr(4'h3, 32'h0, 32'h2);
    ev(EV_NONE, 6'h1, 6'h6);
    hr(4'h3, 32'h2, 32'h2);
    ev(EV_NONE, 6'h0, 6'h6);
    hr(4'h3, 32'h2, 32'h2);
    cwr(REG_STATE, 32'h0001_0059);
    hr(4'h3, 32'h0, 32'h2);
    cwr(REG_STATE, 32'h0081_0058);
    hr(4'h3, 32'h0, 32'h2);
    cwr(REG_STATE, 32'h0081_0059);
    ev(EV_EXC, 6'h0, 6'h0);
    crd(REG_STATE, 32'h0000_000C, 32'h003F_FC0D);
    crd(REG_EXC_SAVED, 32'h0081_0059, '1);
    cwr(REG_STATE, 32'h0080_0051);
    ev(EV_IRQ, 6'h2, 6'h7);
    crd(REG_STATE, 32'h0000_080C, 32'h003F_FC0C);
    ev(EV_EXC, 6'h0, 6'h0);
    crd(REG_STATE, 32'h0, 32'h003F_FC00);
    cwr(REG_STATE, 32'h0080_0055);
    ev(EV_IRQ, 6'h2, 6'h7);
    ev(EV_BREAK, 6'h0, 6'h0);
    crd(REG_STATE, 32'h0002_0000, 32'h003F_FC00);
    crd(REG_BRK_SAVED, 32'h0000_0800, 32'h003F_FC00);
    miss();
    hr(4'h3, 32'h4, 32'h4);
    cmp({31'h0, miss_double_seen}, 32'h1, 32'h1);
    cwr(REG_STATE, 32'h0080_0000);
    miss();
    hr(4'h3, 32'h0, 32'h4);
    cwr(REG_STATE, 32'h0080_0002);
    hr(4'h3, 32'h0, 32'h1);
    cwr(REG_BRK_SAVED, 32'h0);
    ev(EV_EXC, 6'h0, 6'h0);
    hr(4'h3, 32'h1, 32'h1);
    crd(REG_BRK_SAVED, 32'h0000_0800, 32'h003F_FC00);
    ev(EV_NMI, 6'h1, 6'h0);
    crd(REG_STATE, 32'h0040_0000, 32'h0040_0000);
    end_of_test();
  end
endmodule : tb
